// [src/vhc_pkg.sv]
package vhc_pkg;
  // host clock figures
  localparam int CLK_NS = 25;
  // least hold of each strobe phase, in ns, and its cycle count
  localparam int T_PHASE_NS = 50;
  localparam int PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
  // least precharge with every strobe high
  localparam int T_PRECHG_NS = 60;
  localparam int PRECHG_CYC = (T_PRECHG_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets on the APB side
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ROW = 8'h04;
  localparam logic [7:0] OFS_COL = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_LANES = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1C;
  localparam logic [7:0] OFS_SCTRL = 8'h20;
  localparam logic [7:0] OFS_SDATA = 8'h24;
  // reset values
  localparam logic [1:0] LANES_RST = 2'h3;
  localparam logic [7:0] SDIV_RST = 8'h04;
  // field positions
  localparam int ST_BUSY = 0;
  localparam int ST_PERSIST = 1;
  localparam int ST_STOPMODE = 2;
  localparam int ST_HALF = 3;
  localparam int ST_TAPERR = 4;
  localparam int ST_SADDR = 8;
  localparam int SC_RUN = 0;
  localparam int SC_DIV = 8;
  // last split tap of each half that must not be used
  localparam logic [6:0] BAD_TAP = 7'h7F;

  // cycle types a command may request
  typedef enum logic [3:0] {
    CY_READ = 4'h0,
    CY_PLAIN_WRITE = 4'h1,
    CY_MASKED_WRITE = 4'h2,
    CY_AREA_FILL = 4'h3,
    CY_MASKED_FILL = 4'h4,
    CY_MASK_REG_LOAD = 4'h5,
    CY_COLOR_REG_LOAD = 4'h6,
    CY_FULL_XFER = 4'h7,
    CY_HALF_XFER = 4'h8,
    CY_REFRESH_STOP_SET = 4'h9,
    CY_REFRESH_OPT_RESET = 4'hA,
    CY_REFRESH_KEEP = 4'hB
  } vhc_cyc_t;

  // strobe sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_ROW = 3'h2,
    S_COLSET = 3'h3,
    S_COL = 3'h4,
    S_RDOE = 3'h5,
    S_REL = 3'h6
  } vhc_state_t;
endpackage

// [src/vhc_ser_if.sv]
`timescale 1ns/1ps
// link between the strobe sequencer and the serial clock generator
interface vhc_ser_if;
  logic pause; // park the serial clock low during a full transfer
  logic load; // one-cycle pulse: a full transfer completed
  logic [7:0] tap; // start location of that transfer
  logic [7:0] addr; // tracked serial address
  modport seq (output pause, output load, output tap, input addr);
  modport ser (input pause, input load, input tap, output addr);
endinterface

// [src/vhc_timer.sv]
`timescale 1ns/1ps
// down counter that times one strobe phase
module vhc_timer #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_r; // cycles still to wait

  assign done = (cnt_r == '0);

  // reload wins over the count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= value;
    end else if (!done) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// [src/vhc_serial.sv]
`timescale 1ns/1ps
// serial clock generator with host-side view of the serial address
module vhc_serial
  import vhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] div,
  input wire logic [15:0] q_in,
  output logic sclk,
  output logic [15:0] word,
  vhc_ser_if.ser sif
);
  logic [7:0] cnt_r; // cycles left in this half period
  logic sclk_r; // driven serial clock level
  logic [7:0] addr_r; // expected serial address
  logic [15:0] word_r; // last word seen on the serial port
  logic tick; // half period elapsed
  logic stepping; // clock allowed to move

  // a full transfer freezes the serial clock low
  assign stepping = run && !sif.pause;
  assign tick = stepping && (cnt_r == 8'h00);
  assign sclk = sclk_r;
  assign word = word_r;
  assign sif.addr = addr_r;

  // half period counter, divider of zero treated as one
  always_ff @(posedge clk) begin
    if (rst || !stepping || tick) begin
      cnt_r <= (div == 8'h00) ? 8'h00 : div - 8'h01;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // clock edges; parked low when stopped
  always_ff @(posedge clk) begin
    if (rst || (!stepping && !sclk_r)) begin
      sclk_r <= 1'b0;
    end else if (tick || !stepping) begin
      sclk_r <= !sclk_r;
    end
  end

  // address follows every rising edge, output enable or not
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= 8'h00;
    end else if (sif.load) begin
      addr_r <= sif.tap;
    end else if (tick && !sclk_r) begin
      addr_r <= addr_r + 8'h01; // natural 8-bit wrap
    end
  end

  // sample the word at each timed falling edge, half a period after the rising edge; the fall that parks the clock low takes none
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= 16'h0000;
    end else if (tick && sclk_r) begin
      word_r <= q_in;
    end
  end
endmodule

// [src/vhc_host.sv]
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module vhc_host
  import vhc_pkg::*;
#(
  parameter int BLOCK_COLS = 4 // 4 or 8 column fill option
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic ROW_STROBE_N,
  output logic COL_STROBE_LO_N,
  output logic COL_STROBE_HI_N,
  output logic WRITE_STROBE_N,
  output logic FUNC_SELECT,
  output logic XFER_OE_SEL_N,
  output logic [8:0] ADDR,
  input wire logic [15:0] DRAM_IO_I,
  output logic [15:0] DRAM_IO_O,
  output logic [15:0] DRAM_IO_OE,
  output logic SERIAL_CLOCK,
  output logic SHIFT_PORT_OE_N,
  input wire logic [15:0] SHIFT_PORT_Q,
  input wire logic HALF_INDICATOR
);
  // software-visible registers
  logic [3:0] cmd_r; // cycle type of the command under way
  logic [8:0] row_r; // row address, also carries stop code
  logic [8:0] col_r; // column address or tap
  logic [15:0] data_r; // write data, column mask or colour
  logic [15:0] mask_r; // write mask offered at row fall
  logic [1:0] lanes_r; // byte lanes: bit0 low, bit1 high
  logic [15:0] rdata_r; // last word read back
  logic sc_run_r; // serial clock running
  logic [7:0] sdiv_r; // serial half period in clocks
  logic persist_r; // device is in persistent mask mode
  logic stopmode_r; // device is in stop-point mode
  logic taperr_r; // last command write while idle was a split with a bad tap
  logic shift_oe_r; // serial output enable, active high

  // sequencer and pin flops
  vhc_state_t state_r, state_nxt;
  logic ras_n_r, cas_lo_n_r, cas_hi_n_r, we_n_r, dsf_r, trg_n_r;
  logic [8:0] addr_r;
  logic [15:0] io_r;
  logic io_oe_r;
  logic ras_n_nxt, cas_lo_n_nxt, cas_hi_n_nxt, we_n_nxt, dsf_nxt;
  logic trg_n_nxt, io_oe_nxt;
  logic [8:0] addr_nxt;
  logic [15:0] io_nxt;

  // apb decode
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire rd_sel = PSEL && !PWRITE;
  wire hit_cmd = (PADDR == OFS_CMD);
  wire hit_row = (PADDR == OFS_ROW);
  wire hit_col = (PADDR == OFS_COL);
  wire hit_data = (PADDR == OFS_DATA);
  wire hit_mask = (PADDR == OFS_MASK);
  wire hit_lanes = (PADDR == OFS_LANES);
  wire hit_status = (PADDR == OFS_STATUS);
  wire hit_rdata = (PADDR == OFS_RDATA);
  wire hit_sctrl = (PADDR == OFS_SCTRL);
  wire hit_sdata = (PADDR == OFS_SDATA);
  wire mapped = hit_cmd || hit_row || hit_col || hit_data || hit_mask ||
    hit_lanes || hit_status || hit_rdata || hit_sctrl || hit_sdata;
  wire busy = (state_r != S_IDLE);

  // a command is taken only while idle and for a known type
  wire [3:0] new_cyc = PWDATA[3:0];
  wire known = (new_cyc <= CY_REFRESH_KEEP);
  wire bad_tap = (new_cyc == CY_HALF_XFER) &&
    (col_r[6:0] == BAD_TAP);
  wire go = wr_acc && hit_cmd && !busy && known && !bad_tap;

  // cycle class of the command in flight; the command being taken
  // counts already, so the first setup cycle shows its own levels
  // rather than those left over from the previous command
  wire [3:0] cyc = go ? new_cyc : cmd_r;
  wire c_read = (cyc == CY_READ);
  wire c_mwr = (cyc == CY_MASKED_WRITE);
  wire c_fill = (cyc == CY_AREA_FILL);
  wire c_mfill = (cyc == CY_MASKED_FILL);
  wire c_mload = (cyc == CY_MASK_REG_LOAD);
  wire c_cload = (cyc == CY_COLOR_REG_LOAD);
  wire c_full = (cyc == CY_FULL_XFER);
  wire c_half = (cyc == CY_HALF_XFER);
  wire c_sset = (cyc == CY_REFRESH_STOP_SET);
  wire c_ores = (cyc == CY_REFRESH_OPT_RESET);
  wire c_keep = (cyc == CY_REFRESH_KEEP);
  wire c_ref = c_sset || c_ores || c_keep;
  wire c_xfer = c_full || c_half;
  wire c_blk = c_fill || c_mfill;
  wire c_wr = !c_read && !c_xfer && !c_ref;
  // row-time levels
  wire we_row_low = c_mwr || c_mfill || c_sset;
  wire dsf_row = c_half || c_mload || c_cload || c_sset || c_keep;
  // column-time select: fills and colour load
  wire dsf_col = c_blk || c_cload;
  // block address keeps A8 down to A2 or A3
  wire [8:0] blk_keep = (BLOCK_COLS == 8) ? 9'h1F8 : 9'h1FC;
  wire [8:0] col_addr = c_blk ? (col_r & blk_keep) : col_r;
  // stop code is row A4-A7, other bits zero
  wire [8:0] row_addr = c_sset ? {1'b0, row_r[7:4], 4'h0} : row_r;
  // row-time data: write mask for masked cycles
  wire row_io_oe = c_mwr || c_mfill;
  // column mask in fills, low bits only
  wire [15:0] fill_msk = (BLOCK_COLS == 8) ? 16'h00FF : 16'h000F;
  wire [15:0] col_io = c_blk ? (data_r & fill_msk) : data_r;

  // phase timer
  logic t_done;
  wire t_load = (state_nxt != state_r);
  wire [3:0] t_val = (state_nxt == S_REL) ? 4'(PRECHG_CYC - 1) :
    4'(PHASE_CYC - 1);
  vhc_timer #(.W(4)) u_timer (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .load(t_load),
    .value(t_val),
    .done(t_done)
  );

  // serial side; clock parked low across a full transfer
  vhc_ser_if sif ();
  logic [15:0] sword;
  assign sif.pause = c_full && busy;
  assign sif.load = c_full && (state_r == S_REL) && (state_nxt == S_IDLE);
  assign sif.tap = col_r[7:0];
  vhc_serial u_serial (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .run(sc_run_r),
    .div(sdiv_r),
    .q_in(SHIFT_PORT_Q),
    .sclk(SERIAL_CLOCK),
    .word(sword),
    .sif(sif.ser)
  );

  // next state of the strobe sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (go) begin
          state_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        if (t_done) begin
          state_nxt = S_ROW;
        end
      end
      S_ROW: begin
        // refresh has no column phase
        if (t_done) begin
          state_nxt = c_ref ? S_REL : S_COLSET;
        end
      end
      S_COLSET: begin
        if (t_done) begin
          state_nxt = S_COL;
        end
      end
      S_COL: begin
        if (t_done) begin
          state_nxt = c_read ? S_RDOE : S_REL;
        end
      end
      S_RDOE: begin
        if (t_done) begin
          state_nxt = S_REL;
        end
      end
      S_REL: begin
        if (t_done) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // pin levels for the coming state
  always_comb begin
    ras_n_nxt = 1'b1;
    cas_lo_n_nxt = 1'b1;
    cas_hi_n_nxt = 1'b1;
    we_n_nxt = 1'b1;
    dsf_nxt = 1'b0;
    trg_n_nxt = 1'b1;
    addr_nxt = addr_r;
    io_nxt = io_r;
    io_oe_nxt = 1'b0;
    case (state_nxt)
      S_SETUP, S_ROW: begin
        // refresh needs the columns down before the row
        cas_lo_n_nxt = !c_ref;
        cas_hi_n_nxt = !c_ref;
        // transfer select low only for transfers, never in refresh,
        // so the reserved all-low pattern cannot appear
        trg_n_nxt = !c_xfer;
        we_n_nxt = !we_row_low;
        dsf_nxt = dsf_row;
        addr_nxt = row_addr;
        io_nxt = mask_r;
        io_oe_nxt = row_io_oe;
        ras_n_nxt = (state_nxt != S_ROW);
      end
      S_COLSET, S_COL: begin
        ras_n_nxt = 1'b0;
        trg_n_nxt = !c_xfer;
        dsf_nxt = dsf_col;
        addr_nxt = col_addr;
        io_nxt = col_io;
        io_oe_nxt = c_wr;
        // write strobe falls first, so data is latched at col fall
        we_n_nxt = !c_wr;
        // both lanes for transfers, chosen lanes otherwise
        cas_lo_n_nxt = !((state_nxt == S_COL) && (c_xfer || lanes_r[0]));
        cas_hi_n_nxt = !((state_nxt == S_COL) && (c_xfer || lanes_r[1]));
      end
      S_RDOE: begin
        // read: output enable low once both strobes are down
        ras_n_nxt = 1'b0;
        cas_lo_n_nxt = !lanes_r[0];
        cas_hi_n_nxt = !lanes_r[1];
        trg_n_nxt = 1'b0;
        addr_nxt = col_addr;
      end
      default: begin
        // precharge and idle: everything released
      end
    endcase
  end

  // sequencer and pin flops; strobes idle high
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_r <= S_IDLE;
      ras_n_r <= 1'b1;
      cas_lo_n_r <= 1'b1;
      cas_hi_n_r <= 1'b1;
      we_n_r <= 1'b1;
      dsf_r <= 1'b0;
      trg_n_r <= 1'b1;
      addr_r <= 9'h000;
      io_r <= 16'h0000;
      io_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ras_n_r <= ras_n_nxt;
      cas_lo_n_r <= cas_lo_n_nxt;
      cas_hi_n_r <= cas_hi_n_nxt;
      we_n_r <= we_n_nxt;
      dsf_r <= dsf_nxt;
      trg_n_r <= trg_n_nxt;
      addr_r <= addr_nxt;
      io_r <= io_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end

  // read data taken at the end of the output-enable phase
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_r <= 16'h0000;
    end else if (state_r == S_RDOE && t_done) begin
      rdata_r <= DRAM_IO_I;
    end
  end

  // host copy of device modes, updated when the cycle finishes
  wire fin = (state_r == S_REL) && (state_nxt == S_IDLE);
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      persist_r <= 1'b0;
      stopmode_r <= 1'b0;
    end else if (fin) begin
      if (c_mload) begin
        persist_r <= 1'b1;
      end else if (c_ores) begin
        persist_r <= 1'b0;
        stopmode_r <= 1'b0;
      end else if (c_sset) begin
        stopmode_r <= 1'b1;
      end
    end
  end

  // software registers; cmd_r latches only on an accepted go, operand fields whenever idle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cmd_r <= 4'h0;
      row_r <= 9'h000;
      col_r <= 9'h000;
      data_r <= 16'h0000;
      mask_r <= 16'h0000;
      lanes_r <= LANES_RST;
      sc_run_r <= 1'b0;
      sdiv_r <= SDIV_RST;
      shift_oe_r <= 1'b0;
      taperr_r <= 1'b0;
    end else if (wr_acc) begin
      // address fields are frozen while a cycle is on the pins
      if (hit_cmd && go) begin
        cmd_r <= new_cyc;
      end
      if (hit_cmd && !busy) begin
        taperr_r <= bad_tap;
      end
      if (hit_row && !busy) begin
        row_r <= PWDATA[8:0];
      end
      if (hit_col && !busy) begin
        col_r <= PWDATA[8:0];
      end
      if (hit_data && !busy) begin
        data_r <= PWDATA[15:0];
      end
      if (hit_mask && !busy) begin
        mask_r <= PWDATA[15:0];
      end
      if (hit_lanes && !busy) begin
        lanes_r <= PWDATA[1:0];
      end
      if (hit_sctrl) begin
        sc_run_r <= PWDATA[SC_RUN];
        shift_oe_r <= PWDATA[SC_RUN + 1];
        sdiv_r <= PWDATA[SC_DIV +: 8];
      end
    end
  end

  // status word; half flag read back from the device
  wire [31:0] status = {16'h0000, sif.addr, 3'h0, taperr_r,
    HALF_INDICATOR && shift_oe_r, stopmode_r, persist_r, busy};

  // read mux
  wire [31:0] rd_mux =
    hit_cmd ? {28'h0000000, cmd_r} :
    hit_row ? {23'h000000, row_r} :
    hit_col ? {23'h000000, col_r} :
    hit_data ? {16'h0000, data_r} :
    hit_mask ? {16'h0000, mask_r} :
    hit_lanes ? {30'h00000000, lanes_r} :
    hit_status ? status :
    hit_rdata ? {16'h0000, rdata_r} :
    hit_sctrl ? {16'h0000, sdiv_r, 6'h00, shift_oe_r, sc_run_r} :
    hit_sdata ? {16'h0000, sword} : 32'h00000000;

  assign PRDATA = (rd_sel && mapped) ? rd_mux : 32'h00000000;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // pins
  assign ROW_STROBE_N = ras_n_r;
  assign COL_STROBE_LO_N = cas_lo_n_r;
  assign COL_STROBE_HI_N = cas_hi_n_r;
  assign WRITE_STROBE_N = we_n_r;
  assign FUNC_SELECT = dsf_r;
  assign XFER_OE_SEL_N = trg_n_r;
  assign ADDR = addr_r;
  assign DRAM_IO_O = io_r;
  assign DRAM_IO_OE = {16{io_oe_r}};
  assign SHIFT_PORT_OE_N = !shift_oe_r;
endmodule

// [bench/vhc_host_chk.sv]
`timescale 1ns/1ps
// pin-level watch on the strobe side of the host
module vhc_host_chk (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic ROW_STROBE_N,
  input wire logic COL_STROBE_LO_N,
  input wire logic COL_STROBE_HI_N,
  input wire logic WRITE_STROBE_N,
  input wire logic FUNC_SELECT,
  input wire logic XFER_OE_SEL_N,
  input wire logic [8:0] ADDR,
  input wire logic [15:0] DRAM_IO_OE,
  input wire logic SERIAL_CLOCK
);
  // column strobe as the device sees it: low if either lane is low
  wire cas_n = COL_STROBE_LO_N & COL_STROBE_HI_N;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_rst_idle: assert property (disable iff (1'h0)
    SYS_RST |=> ROW_STROBE_N && cas_n && !SERIAL_CLOCK && DRAM_IO_OE == 16'h0)
    else $error("pins not idle after reset");
  a_row_hold: assert property (
    $fell(ROW_STROBE_N) |=> !ROW_STROBE_N)
    else $error("row strobe low for less than two cycles");
  a_precharge: assert property (
    $rose(ROW_STROBE_N) |-> ROW_STROBE_N [*3])
    else $error("precharge shorter than three cycles");
  a_no_reserved: assert property (
    $fell(ROW_STROBE_N) |->
      !(!cas_n && !XFER_OE_SEL_N && !WRITE_STROBE_N && !FUNC_SELECT))
    else $error("reserved level set at row fall");
  a_cbr_order: assert property (
    $fell(ROW_STROBE_N) && !cas_n |-> !$past(cas_n))
    else $error("column strobe not ahead of row in refresh");
  a_col_addr: assert property (
    $fell(cas_n) && !ROW_STROBE_N |-> $stable(ADDR) ##1 $stable(ADDR))
    else $error("address moved around column fall");
  a_data_at_col: assert property (
    $fell(cas_n) && !ROW_STROBE_N && !WRITE_STROBE_N |->
      DRAM_IO_OE == 16'hFFFF)
    else $error("write data not driven at column fall");
  a_xfer_levels: assert property (
    $fell(ROW_STROBE_N) && !XFER_OE_SEL_N |-> WRITE_STROBE_N && cas_n)
    else $error("transfer levels wrong at row fall");
  a_sclk_pause: assert property (
    $fell(ROW_STROBE_N) && !XFER_OE_SEL_N && !FUNC_SELECT |->
      $stable(SERIAL_CLOCK) [*4])
    else $error("serial clock moved during full transfer");
  c_refresh: cover property ($fell(ROW_STROBE_N) && !cas_n);
  c_xfer: cover property ($fell(ROW_STROBE_N) && !XFER_OE_SEL_N);
  c_fill: cover property ($fell(cas_n) && FUNC_SELECT && !ROW_STROBE_N);
endmodule
bind vhc_host vhc_host_chk i_vhc_host_chk (.CLK_SYS, .SYS_RST,
  .ROW_STROBE_N, .COL_STROBE_LO_N, .COL_STROBE_HI_N, .WRITE_STROBE_N,
  .FUNC_SELECT, .XFER_OE_SEL_N, .ADDR, .DRAM_IO_OE, .SERIAL_CLOCK);

// [bench/vhc_dev_model.sv]
`timescale 1ns/1ps
// device stand-in; rows alias onto one row to keep the model small
module vhc_dev_model #(
  parameter int BC = 4 // columns per block fill
) (
  input wire logic ras_n,
  input wire logic cas_lo_n,
  input wire logic cas_hi_n,
  input wire logic we_n,
  input wire logic func_select,
  input wire logic trg_n,
  input wire logic [8:0] a,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic sc,
  input wire logic se_n,
  output logic [15:0] sq,
  output logic half_indicator
);
  logic [15:0] mem [512]; // array words by column
  logic [15:0] shift_register_memory [256]; // serial register
  logic [15:0] mask_r, color_r, wm; // stored mask, colour, live mask
  logic rc, rt, rw, rd, first, persist, stop; // row-fall levels, modes
  logic [3:0] stop_code; // stop point code
  logic [8:0] col; // latched column
  logic [7:0] cnt; // serial address counter
  wire cas_n = cas_lo_n & cas_hi_n;
  wire rdg = !ras_n && !cas_n && !trg_n && we_n; // read window
  wire [15:0] lm = rw ? 16'hFFFF : wm;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0;
    foreach (shift_register_memory[i]) shift_register_memory[i] = 16'h0;
    {persist, stop, cnt, first} = 11'h0;
  end
  // a released bus shows the inverse, never a stale word
  assign dq_o = rdg ? mem[col] : ~mem[col];
  // disabled outputs float: show the inverse
  assign sq = se_n ? ~shift_register_memory[cnt] : shift_register_memory[cnt];
  assign half_indicator = se_n ? ~cnt[7] : cnt[7];
  // row fall: levels decide the cycle
  always @(negedge ras_n) begin
    rc = cas_n;
    rt = trg_n;
    rw = we_n;
    rd = func_select;
    first = 1'h1;
    wm = persist ? mask_r : dq_i;
    if (!rc && !rw && rd) begin
      stop = 1'h1;
      stop_code = a[7:4];
    end else if (!rc && rw && !rd) begin
      persist = 1'h0;
      stop = 1'h0;
    end // keep refresh touches no mode
  end
  // first column fall: address, data and function
  always @(negedge cas_n) begin
    if (!ras_n && rc && first) begin
      first = 1'h0;
      col = a;
      if (!rt && !rd) begin
        for (int i = 0; i < 256; i++) shift_register_memory[i] = mem[{a[8], 8'(i)}];
        cnt = a[7:0];
      end else if (!rt) begin // idle half only
        for (int i = 0; i < 128; i++)
          shift_register_memory[{~cnt[7], 7'(i)}] = mem[{a[8], ~cnt[7], 7'(i)}];
      end else if (rw && rd && !func_select) begin
        mask_r = dq_i;
        persist = 1'h1;
      end else if (rw && rd) begin
        color_r = dq_i;
      end else if (!we_n && func_select) begin
        for (int j = 0; j < BC; j++)
          if (dq_i[j])
            mem[(a & ~9'(BC - 1)) + 9'(j)] =
              (mem[(a & ~9'(BC - 1)) + 9'(j)] & ~lm) | (color_r & lm);
      end else if (!we_n) begin
        mem[a] = (mem[a] & ~lm) | (dq_i & lm);
      end
    end
  end
  // every rise steps the counter, wrapping at the top
  always @(posedge sc) cnt = cnt + 8'h1;
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
// host bench: apb orders in, device model behind the pins
module testbench;
  import vhc_pkg::*;
  logic CLK_SYS, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic ROW_STROBE_N, COL_STROBE_LO_N, COL_STROBE_HI_N, WRITE_STROBE_N;
  logic FUNC_SELECT, XFER_OE_SEL_N, SERIAL_CLOCK, SHIFT_PORT_OE_N;
  logic HALF_INDICATOR;
  logic [8:0] ADDR;
  logic [15:0] DRAM_IO_I, DRAM_IO_O, DRAM_IO_OE, SHIFT_PORT_Q, dq_dev;
  logic [31:0] v; // last read word
  logic e; // last error flag
  int n_fail = 0;
  int tests_run = 0;
  // bus level: host bits win where it drives
  assign DRAM_IO_I = (DRAM_IO_OE & DRAM_IO_O) | (~DRAM_IO_OE & dq_dev);
  vhc_host #(.BLOCK_COLS(4)) i_vhc_host (.CLK_SYS, .SYS_RST, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .ROW_STROBE_N, .COL_STROBE_LO_N, .COL_STROBE_HI_N, .WRITE_STROBE_N,
    .FUNC_SELECT, .XFER_OE_SEL_N, .ADDR, .DRAM_IO_I, .DRAM_IO_O,
    .DRAM_IO_OE, .SERIAL_CLOCK, .SHIFT_PORT_OE_N, .SHIFT_PORT_Q,
    .HALF_INDICATOR);
  vhc_dev_model #(.BC(4)) i_vhc_dev_model (.ras_n(ROW_STROBE_N),
    .cas_lo_n(COL_STROBE_LO_N), .cas_hi_n(COL_STROBE_HI_N),
    .we_n(WRITE_STROBE_N), .func_select(FUNC_SELECT), .trg_n(XFER_OE_SEL_N),
    .a(ADDR), .dq_i(DRAM_IO_I), .dq_o(dq_dev), .sc(SERIAL_CLOCK),
    .se_n(SHIFT_PORT_OE_N), .sq(SHIFT_PORT_Q), .half_indicator(HALF_INDICATOR));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and stop
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one apb transfer; an idle edge after so drivers never clash
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
    v = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK_SYS);
  endtask
  // read a register and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
    input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, v, x);
  endtask
  // compare one status bit
  task automatic stb(input int b, input logic x, input string nm);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(nm, {31'h0, v[b]}, {31'h0, x});
  endtask
  // load operands, start a cycle, wait till idle (bounded)
  task automatic op(input vhc_cyc_t t, input logic [8:0] r, c,
    input logic [15:0] d, m);
    int n;
    n = 0;
    apb(1'h1, OFS_ROW, {23'h0, r});
    apb(1'h1, OFS_COL, {23'h0, c});
    apb(1'h1, OFS_DATA, {16'h0, d});
    apb(1'h1, OFS_MASK, {16'h0, m});
    apb(1'h1, OFS_CMD, {28'h0, t});
    do begin
      apb(1'h0, OFS_STATUS, 32'h0);
      n++;
    end while (v[ST_BUSY] !== 1'h0 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
  endtask
  // read one column back through a read cycle
  task automatic rcol(input logic [8:0] c, input logic [15:0] x);
    op(CY_READ, 9'h0, c, 16'h0, 16'h0);
    rdc(OFS_RDATA, {16'h0, x}, "column");
  endtask
  // expected serial word at a location after the full transfer
  function automatic logic [15:0] em(input logic [7:0] s);
    case (s)
      8'h05: return 16'h02FF;
      8'h08, 8'h0A: return 16'hBEEF;
      8'h0D: return 16'h00EF;
      default: return 16'h0;
    endcase
  endfunction
  initial begin
    CLK_SYS = 1'h0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    {SYS_RST, PSEL, PENABLE, PWRITE} = 4'h8;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    repeat (12) @(posedge CLK_SYS);
    SYS_RST <= 1'h0;
    @(posedge CLK_SYS);
    rdc(OFS_LANES, 32'h3, "lanes");
    rdc(OFS_SCTRL, 32'h400, "sctrl");
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    op(CY_PLAIN_WRITE, 9'h0, 9'h5, 16'h1234, 16'h0);
    rcol(9'h5, 16'h1234);
    op(CY_MASK_REG_LOAD, 9'h0, 9'h0, 16'h00FF, 16'h0);
    stb(ST_PERSIST, 1'h1, "persist");
    op(CY_MASKED_WRITE, 9'h0, 9'h5, 16'hFFFF, 16'h0);
    rcol(9'h5, 16'h12FF);
    op(CY_REFRESH_KEEP, 9'h0, 9'h0, 16'h0, 16'h0);
    stb(ST_PERSIST, 1'h1, "keep");
    op(CY_REFRESH_STOP_SET, 9'h0A0, 9'h0, 16'h0, 16'h0);
    stb(ST_STOPMODE, 1'h1, "stop");
    op(CY_REFRESH_OPT_RESET, 9'h0, 9'h0, 16'h0, 16'h0);
    stb(ST_PERSIST, 1'h0, "clr persist");
    stb(ST_STOPMODE, 1'h0, "clr stop");
    op(CY_MASKED_WRITE, 9'h0, 9'h5, 16'h0, 16'hF000);
    rcol(9'h5, 16'h02FF);
    op(CY_COLOR_REG_LOAD, 9'h0, 9'h0, 16'hBEEF, 16'h0);
    op(CY_AREA_FILL, 9'h0, 9'h9, 16'h0005, 16'h0);
    for (int c = 8; c < 12; c++) begin
      rcol(9'(c), (c == 8 || c == 10) ? 16'hBEEF : 16'h0);
    end
    op(CY_MASKED_FILL, 9'h0, 9'hC, 16'h0002, 16'h00FF);
    rcol(9'hD, 16'h00EF);
    op(CY_HALF_XFER, 9'h0, 9'h07F, 16'h0, 16'h0);
    stb(ST_TAPERR, 1'h1, "tap");
    op(CY_HALF_XFER, 9'h0, 9'h005, 16'h0, 16'h0);
    stb(ST_TAPERR, 1'h0, "tap ok");
    op(CY_FULL_XFER, 9'h0, 9'h0FE, 16'h0, 16'h0);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("start", {24'h0, v[15:8]}, 32'hFE);
    apb(1'h1, OFS_SCTRL, 32'h0103);
    repeat (20) @(posedge CLK_SYS);
    apb(1'h1, OFS_SCTRL, 32'h0102);
    repeat (10) @(posedge CLK_SYS);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("wrap", {31'h0, v[15:8] < 8'h20}, 32'h1);
    chk("half", {31'h0, v[ST_HALF]}, {31'h0, v[15]});
    rdc(OFS_SDATA, {16'h0, em(v[15:8])}, "serial");
    end_sim();
  end
endmodule
